// File: logic/priv_check_pkg.sv
// Package: constants, opcodes and carriers for the privilege gate
package priv_check_pkg;

    // ********************************************
    // Field positions and reset values
    // ********************************************
    localparam int PREVENT_BIT = 11;
    localparam int FEATURE_COUNT_BIT = 2;
    localparam logic [31:0] FEATURE_LEAF = 32'h0000_0007;
    localparam logic [15:0] FAULT_CODE_ZERO = 16'h0000;
    localparam logic [1:0] LEVEL_ZERO = 2'h0;
    localparam logic [63:0] CTRL_FOUR_RESET = 64'h0000_0000_0000_0000;

    // ********************************************
    // Instruction codes presented to the gate
    // ********************************************
    typedef enum logic [5:0] {
        OP_NONE = 6'h00,
        OP_STORE_GLOBAL_TABLE_REG = 6'h01,
        OP_STORE_INTERRUPT_TABLE_REG = 6'h02,
        OP_STORE_LOCAL_TABLE_REG = 6'h03,
        OP_STORE_MACHINE_STATUS_WORD = 6'h04,
        OP_STORE_TASK_REGISTER = 6'h05,
        OP_MARK_SHADOW_BUSY = 6'h06,
        OP_SECURE_ATTESTED_LAUNCH = 6'h07,
        OP_SET_GLOBAL_IRQ_FLAG = 6'h08,
        OP_SEGMENT_BASE_EXCHANGE = 6'h09,
        OP_FAST_SYSTEM_RETURN = 6'h0a,
        OP_LEGACY_SYSTEM_EXIT = 6'h0b,
        OP_CACHE_WRITEBACK_INVALIDATE = 6'h0c,
        OP_CACHE_WRITEBACK_KEEP = 6'h0d,
        OP_MODEL_SPECIFIC_REG_WRITE = 6'h0e,
        OP_GUEST_STATE_LOAD = 6'h0f,
        OP_GUEST_STATE_SAVE = 6'h10,
        OP_MONITOR_CALL = 6'h11,
        OP_GUEST_RUN = 6'h12,
        OP_USER_SHADOW_STACK_WRITE = 6'h13,
        OP_FIRST_SEG_BASE_WRITE = 6'h14,
        OP_SECOND_SEG_BASE_WRITE = 6'h15,
        OP_SEGMENT_READ_CHECK = 6'h16,
        OP_SEGMENT_WRITE_CHECK = 6'h17,
        OP_SHADOW_STACK_WRITE = 6'h18,
        OP_SHADOW_POINTER_RESTORE = 6'h19,
        OP_SHADOW_POINTER_SAVE_PRIOR = 6'h1a,
        OP_FAST_SYSTEM_CALL = 6'h1b,
        OP_LEGACY_SYSTEM_ENTER = 6'h1c,
        OP_SET_ALIGNMENT_OVERRIDE = 6'h1d,
        OP_SET_INTERRUPT_ENABLE = 6'h1e,
        OP_CONTROL_REGISTER_FOUR_WRITE = 6'h1f,
        OP_FEATURE_IDENTIFICATION_QUERY = 6'h20
    } instr_code_t;

    // Privilege class of an instruction
    typedef enum logic [1:0] {
        CLASS_ANY = 2'b00,
        CLASS_LEVEL0 = 2'b01,
        CLASS_OS = 2'b10
    } priv_class_t;

    // One instruction request
    typedef struct packed {
        logic valid;
        instr_code_t code;
        logic [1:0] level;
        logic [63:0] operand;
    } instr_req_t;

    // One verdict
    typedef struct packed {
        logic valid;
        logic execute;
        logic fault;
        logic [15:0] error_code;
        logic has_error_code;
    } verdict_t;

endpackage : priv_check_pkg

// File: logic/system_instr_privilege_check.sv
// Privilege gate for system-management instructions
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ns
`default_nettype none

module system_instr_privilege_check
    import priv_check_pkg::*;
#(
    parameter bit FEATURE_SUPPORTED = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Instruction request from the core
    input wire instr_req_t req_in,
    // OS-chosen level needed per OS-controlled instruction
    input wire logic [1:0] os_level_store_tables_in,
    input wire logic [1:0] os_level_alignment_in,
    input wire logic [1:0] os_level_interrupt_in,
    // Verdict and state
    output var verdict_t verdict_out,
    output logic [31:0] count_register_out,
    output logic user_instr_prevention_out
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Class of each instruction; unlisted codes are treated as level 0
    function automatic priv_class_t class_of(input instr_code_t c);
        priv_class_t k;
        k = CLASS_LEVEL0;
        unique case (c)
            OP_MARK_SHADOW_BUSY,
            OP_SECURE_ATTESTED_LAUNCH,
            OP_SET_GLOBAL_IRQ_FLAG,
            OP_SEGMENT_BASE_EXCHANGE,
            OP_FAST_SYSTEM_RETURN,
            OP_LEGACY_SYSTEM_EXIT,
            OP_CACHE_WRITEBACK_INVALIDATE,
            OP_CACHE_WRITEBACK_KEEP,
            OP_MODEL_SPECIFIC_REG_WRITE,
            OP_GUEST_STATE_LOAD,
            OP_GUEST_STATE_SAVE,
            OP_MONITOR_CALL,
            OP_GUEST_RUN,
            OP_USER_SHADOW_STACK_WRITE,
            OP_CONTROL_REGISTER_FOUR_WRITE: k = CLASS_LEVEL0;
            OP_FIRST_SEG_BASE_WRITE,
            OP_SECOND_SEG_BASE_WRITE,
            OP_SEGMENT_READ_CHECK,
            OP_SEGMENT_WRITE_CHECK,
            OP_SHADOW_STACK_WRITE,
            OP_SHADOW_POINTER_RESTORE,
            OP_SHADOW_POINTER_SAVE_PRIOR,
            OP_FAST_SYSTEM_CALL,
            OP_LEGACY_SYSTEM_ENTER,
            OP_FEATURE_IDENTIFICATION_QUERY,
            OP_NONE: k = CLASS_ANY;
            OP_STORE_GLOBAL_TABLE_REG,
            OP_STORE_INTERRUPT_TABLE_REG,
            OP_STORE_LOCAL_TABLE_REG,
            OP_STORE_MACHINE_STATUS_WORD,
            OP_STORE_TASK_REGISTER,
            OP_SET_ALIGNMENT_OVERRIDE,
            OP_SET_INTERRUPT_ENABLE: k = CLASS_OS;
            default: k = CLASS_LEVEL0;
        endcase
        return k;
    endfunction

    // The five store instructions gated by the prevention mode
    function automatic logic is_guarded_store(input instr_code_t c);
        return (c == OP_STORE_GLOBAL_TABLE_REG) ||
               (c == OP_STORE_INTERRUPT_TABLE_REG) ||
               (c == OP_STORE_LOCAL_TABLE_REG) ||
               (c == OP_STORE_MACHINE_STATUS_WORD) ||
               (c == OP_STORE_TASK_REGISTER);
    endfunction

    // ****************************************************************
    // Combinational verdict
    // ****************************************************************
    priv_class_t cls;
    logic [1:0] os_need;
    logic level_fault;
    logic prevent_fault;
    logic ctrl_four_fault;
    logic ctrl_four_write;

    // OS-selected level; a level above it faults
    always_comb begin
        unique case (req_in.code)
            OP_SET_ALIGNMENT_OVERRIDE: os_need = os_level_alignment_in;
            OP_SET_INTERRUPT_ENABLE: os_need = os_level_interrupt_in;
            default: os_need = os_level_store_tables_in;
        endcase
    end

    assign cls = class_of(req_in.code);
    assign ctrl_four_write = req_in.valid &&
        req_in.code == OP_CONTROL_REGISTER_FOUR_WRITE &&
        req_in.level == LEVEL_ZERO;
    // Prevention overrides the OS choice for the five stores
    assign prevent_fault = user_instr_prevention_out &&
        is_guarded_store(req_in.code) && req_in.level != LEVEL_ZERO;
    assign level_fault =
        (cls == CLASS_LEVEL0 && req_in.level != LEVEL_ZERO) ||
        (cls == CLASS_OS && req_in.level > os_need);
    // Setting the enable bit without the feature is refused
    assign ctrl_four_fault = ctrl_four_write && !FEATURE_SUPPORTED &&
        req_in.operand[PREVENT_BIT];

    // ****************************************************************
    // Registered outputs
    // ****************************************************************

    // Verdict one cycle after the request
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            verdict_out <= '0;
        end else begin
            verdict_out.valid <= req_in.valid;
            verdict_out.fault <= req_in.valid &&
                (level_fault || prevent_fault || ctrl_four_fault);
            verdict_out.execute <= req_in.valid &&
                !(level_fault || prevent_fault || ctrl_four_fault);
            // Error code 0, flagged as present only on prevention faults
            verdict_out.error_code <= FAULT_CODE_ZERO;
            verdict_out.has_error_code <= req_in.valid && prevent_fault;
        end
    end

    // Control register four prevention bit; a faulting write is dropped
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            user_instr_prevention_out <= CTRL_FOUR_RESET[PREVENT_BIT];
        end else if (ctrl_four_write && !ctrl_four_fault) begin
            user_instr_prevention_out <=
                req_in.operand[PREVENT_BIT];
        end
    end

    // Feature query answer; only leaf 7 reports the support bit
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            count_register_out <= '0;
        end else if (req_in.valid &&
                     req_in.code == OP_FEATURE_IDENTIFICATION_QUERY) begin
            count_register_out <= '0;
            if (req_in.operand[31:0] == FEATURE_LEAF) begin
                count_register_out[FEATURE_COUNT_BIT] <=
                    FEATURE_SUPPORTED;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    AST_STORE_FAULT: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && user_instr_prevention_out &&
         is_guarded_store(req_in.code) && req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && verdict_out.has_error_code &&
             verdict_out.error_code == 16'h0000))
        else $error("guarded store above level 0 did not fault");

    AST_LEVEL0_BLOCK: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && class_of(req_in.code) == CLASS_LEVEL0 &&
         req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("level 0 instruction ran above level 0");

    AST_ANY_LEVEL: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && class_of(req_in.code) == CLASS_ANY)
        |=> (verdict_out.execute && !verdict_out.fault))
        else $error("any-level instruction was refused");

    AST_ENABLE_SET: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (ctrl_four_write && req_in.operand[PREVENT_BIT] && FEATURE_SUPPORTED)
        |=> user_instr_prevention_out)
        else $error("prevention enable not taken");

    AST_UNSUPPORTED: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (ctrl_four_write && req_in.operand[PREVENT_BIT] && !FEATURE_SUPPORTED)
        |=> (verdict_out.fault && $stable(user_instr_prevention_out)))
        else $error("unsupported enable write did not fault");

    AST_FEATURE_BIT: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_FEATURE_IDENTIFICATION_QUERY &&
         req_in.operand[31:0] == 32'h0000_0007)
        |=> (count_register_out[2] == FEATURE_SUPPORTED))
        else $error("feature bit wrong for leaf 7");

    AST_OS_LEVEL: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_SET_INTERRUPT_ENABLE &&
         req_in.level <= os_level_interrupt_in)
        |=> verdict_out.execute)
        else $error("OS-permitted instruction refused");

    AST_NO_BOTH: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        verdict_out.valid == (verdict_out.execute ^ verdict_out.fault))
        else $error("verdict is not exactly one of execute and fault");

    // A user-level busy mark could claim a supervisor shadow stack token
    AST_SHADOW_BUSY: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_MARK_SHADOW_BUSY &&
         req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("shadow busy mark ran above level 0");

    // Attested launch reinitialises the machine, so kernel only
    AST_SECURE_LAUNCH: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_SECURE_ATTESTED_LAUNCH &&
         req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("attested launch ran above level 0");

    // Opening the global interrupt gate belongs to the monitor
    AST_GLOBAL_IRQ: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_SET_GLOBAL_IRQ_FLAG &&
         req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("global interrupt flag set above level 0");

    // Base exchange and both system returns change privilege state
    AST_SYSTEM_RETURN: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.level != LEVEL_ZERO &&
         (req_in.code == OP_SEGMENT_BASE_EXCHANGE ||
          req_in.code == OP_FAST_SYSTEM_RETURN ||
          req_in.code == OP_LEGACY_SYSTEM_EXIT))
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("base exchange or system return ran above level 0");

    // Cache flushes and model register writes affect the whole core
    AST_CACHE_MSR: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.level != LEVEL_ZERO &&
         (req_in.code == OP_CACHE_WRITEBACK_INVALIDATE ||
          req_in.code == OP_CACHE_WRITEBACK_KEEP ||
          req_in.code == OP_MODEL_SPECIFIC_REG_WRITE))
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("cache or model register op ran above level 0");

    // Guest control is for the monitor only
    AST_GUEST_OPS: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.level != LEVEL_ZERO &&
         (req_in.code == OP_GUEST_STATE_LOAD ||
          req_in.code == OP_GUEST_STATE_SAVE ||
          req_in.code == OP_MONITOR_CALL ||
          req_in.code == OP_GUEST_RUN))
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("guest operation ran above level 0");

    // User shadow stack writes come from the kernel on behalf of users
    AST_USER_SHADOW: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_USER_SHADOW_STACK_WRITE &&
         req_in.level != LEVEL_ZERO)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("user shadow stack write ran above level 0");

    // Segment base writes are user features and never fault here
    AST_SEG_BASE_ANY: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && (req_in.code == OP_FIRST_SEG_BASE_WRITE ||
                          req_in.code == OP_SECOND_SEG_BASE_WRITE))
        |=> (verdict_out.execute && !verdict_out.fault))
        else $error("segment base write was refused");

    // Segment checks only report rights, so any level may ask
    AST_SEG_CHECK_ANY: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && (req_in.code == OP_SEGMENT_READ_CHECK ||
                          req_in.code == OP_SEGMENT_WRITE_CHECK))
        |=> (verdict_out.execute && !verdict_out.fault))
        else $error("segment check was refused");

    // Prevention narrows the five stores to level 0, it does not ban them
    AST_STORE_LEVEL0: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && user_instr_prevention_out &&
         is_guarded_store(req_in.code) && req_in.level == LEVEL_ZERO)
        |=> (verdict_out.execute && !verdict_out.fault))
        else $error("guarded store refused at level 0");

    // Above the configured level an OS-controlled instruction faults
    AST_OS_FAULT: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && cls == CLASS_OS && req_in.level > os_need)
        |=> (verdict_out.fault && !verdict_out.execute))
        else $error("OS-controlled instruction ran above its level");

    // Only a fault may carry an error code, and that code is zero
    AST_ERROR_CODE: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        verdict_out.has_error_code
        |-> (verdict_out.fault && verdict_out.error_code == FAULT_CODE_ZERO))
        else $error("error code without a fault or not zero");

    // Writing the enable bit as 0 turns prevention back off
    AST_ENABLE_CLEAR: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (ctrl_four_write && !req_in.operand[PREVENT_BIT])
        |=> !user_instr_prevention_out)
        else $error("prevention enable not cleared");

    // A user-level control register write must leave the enable alone
    AST_USER_WRITE_DROPPED: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (req_in.valid && req_in.code == OP_CONTROL_REGISTER_FOUR_WRITE &&
         req_in.level != LEVEL_ZERO)
        |=> $stable(user_instr_prevention_out))
        else $error("user-level control register write took effect");

endmodule // system_instr_privilege_check

`default_nettype wire

// File: verif/system_instr_privilege_check_bench.sv
// Self-checking bench for the system instruction privilege gate
`timescale 1ns/1ns
`default_nettype none

module system_instr_privilege_check_bench import priv_check_pkg::*;;
    logic clk_sys_in;
    logic rst_n_in;
    instr_req_t req;
    logic [1:0] os_st;
    logic [1:0] os_al;
    logic [1:0] os_ir;
    verdict_t vd;
    verdict_t vd_nf;
    verdict_t got;
    verdict_t got_nf;
    logic [31:0] cnt;
    logic [31:0] cnt_nf;
    logic prev;
    logic prev_nf;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    instr_code_t lvl0_codes[14] = '{OP_MARK_SHADOW_BUSY,
        OP_SECURE_ATTESTED_LAUNCH, OP_SET_GLOBAL_IRQ_FLAG,
        OP_SEGMENT_BASE_EXCHANGE, OP_FAST_SYSTEM_RETURN,
        OP_LEGACY_SYSTEM_EXIT, OP_CACHE_WRITEBACK_INVALIDATE,
        OP_CACHE_WRITEBACK_KEEP, OP_MODEL_SPECIFIC_REG_WRITE,
        OP_GUEST_STATE_LOAD, OP_GUEST_STATE_SAVE, OP_MONITOR_CALL,
        OP_GUEST_RUN, OP_USER_SHADOW_STACK_WRITE};
    instr_code_t any_codes[9] = '{OP_FIRST_SEG_BASE_WRITE,
        OP_SECOND_SEG_BASE_WRITE, OP_SEGMENT_READ_CHECK,
        OP_SEGMENT_WRITE_CHECK, OP_SHADOW_STACK_WRITE,
        OP_SHADOW_POINTER_RESTORE, OP_SHADOW_POINTER_SAVE_PRIOR,
        OP_FAST_SYSTEM_CALL, OP_LEGACY_SYSTEM_ENTER};
    instr_code_t os_codes[7] = '{OP_STORE_GLOBAL_TABLE_REG,
        OP_STORE_INTERRUPT_TABLE_REG, OP_STORE_LOCAL_TABLE_REG,
        OP_STORE_MACHINE_STATUS_WORD, OP_STORE_TASK_REGISTER,
        OP_SET_ALIGNMENT_OVERRIDE, OP_SET_INTERRUPT_ENABLE};

    // ****************************************
    // Devices: one with the feature, one without
    // ****************************************
    system_instr_privilege_check u_system_instr_privilege_check (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
        .os_level_store_tables_in(os_st), .os_level_alignment_in(os_al),
        .os_level_interrupt_in(os_ir), .verdict_out(vd),
        .count_register_out(cnt), .user_instr_prevention_out(prev));
    system_instr_privilege_check #(.FEATURE_SUPPORTED(1'b0))
        u_system_instr_privilege_check_nf (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
        .os_level_store_tables_in(os_st), .os_level_alignment_in(os_al),
        .os_level_interrupt_in(os_ir), .verdict_out(vd_nf),
        .count_register_out(cnt_nf), .user_instr_prevention_out(prev_nf));

    // Clock and hang guard; limit is far above the expected few hundred
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] expected);
        checks_done++;
        if (seen !== expected) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, expected, seen);
        end
    endtask
    // One request; verdict is sampled at the next falling edge
    task automatic issue(input instr_code_t code, input logic [1:0] level,
                         input logic [63:0] operand);
        @(negedge clk_sys_in);
        req = '{valid: 1'b1, code: code, level: level, operand: operand};
        @(negedge clk_sys_in);
        req.valid = 1'b0;
        got = vd;
        got_nf = vd_nf;
    endtask
    task automatic verdict_is(input string what, input logic ex,
                              input logic flt, input logic hc);
        check(what, {got.valid, got.execute, got.fault, got.has_error_code,
            got.error_code}, {1'b1, ex, flt, hc, FAULT_CODE_ZERO});
    endtask
    task automatic do_reset();
        rst_n_in = 1'b0;
        repeat (20) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_fixed_levels();
        foreach (lvl0_codes[i]) begin
            for (int l = 0; l < 4; l++) begin
                issue(lvl0_codes[i], 2'(l), 64'h0);
                verdict_is(lvl0_codes[i].name(),
                    l == 0, l != 0,
                    1'b0);
            end
        end
        foreach (any_codes[i]) begin
            issue(any_codes[i], 2'h3, 64'h0);
            verdict_is(any_codes[i].name(), 1'b1, 1'b0,
                1'b0);
        end
        $display("test fixed_levels done");
    endtask

    task automatic test_os_levels();
        logic [1:0] lim;
        os_st = 2'h1;
        os_al = 2'h2;
        os_ir = 2'h0;
        foreach (os_codes[i]) begin
            lim = (i == 5) ? os_al : (i == 6) ? os_ir : os_st;
            for (int l = 0; l < 4; l++) begin
                issue(os_codes[i], 2'(l), 64'h0);
                verdict_is(os_codes[i].name(), l <= lim, l > lim,
                    1'b0);
            end
        end
        $display("test os_levels done");
    endtask

    task automatic test_query();
        issue(OP_FEATURE_IDENTIFICATION_QUERY, 2'h3, {32'h0, FEATURE_LEAF});
        check("count_register", cnt, 32'h1 << FEATURE_COUNT_BIT);
        check("count_register_nf", cnt_nf, 32'h0);
        issue(OP_FEATURE_IDENTIFICATION_QUERY, 2'h0, 64'h1);
        check("count_register_other_leaf", cnt, 32'h0);
        // The answer must stand across instructions that are not queries
        issue(OP_FEATURE_IDENTIFICATION_QUERY, 2'h1, {32'h0, FEATURE_LEAF});
        issue(OP_GUEST_RUN, 2'h3, 64'h0);
        verdict_is("guest_run_user", 1'b0, 1'b1, 1'b0);
        check("count_register_held", cnt,
            32'h1 << FEATURE_COUNT_BIT);
        // A verdict stands for one cycle only
        @(negedge clk_sys_in);
        check("verdict_one_cycle", vd.valid, 1'b0);
        $display("test query done");
    endtask

    task automatic test_prevention();
        logic [63:0] on_val;
        on_val = 64'h1 << PREVENT_BIT;
        os_st = 2'h3;
        issue(OP_CONTROL_REGISTER_FOUR_WRITE, 2'h3, on_val);
        verdict_is("ctrl_four_write_user", 1'b0, 1'b1, 1'b0);
        check("prevention_after_user", prev, 1'b0);
        issue(OP_CONTROL_REGISTER_FOUR_WRITE, 2'h0, on_val);
        check("prevention_on", prev, 1'b1);
        check("nf_fault", got_nf.fault, 1'b1);
        check("nf_prevention", prev_nf, 1'b0);
        for (int i = 0; i < 5; i++) begin
            issue(os_codes[i], 2'h3, 64'h0);
            verdict_is(os_codes[i].name(), 1'b0, 1'b1,
                1'b1);
            issue(os_codes[i], 2'h0, 64'h0);
            verdict_is(os_codes[i].name(), 1'b1, 1'b0, 1'b0);
        end
        issue(OP_SET_ALIGNMENT_OVERRIDE, 2'h2, 64'h0);
        verdict_is("alignment_untouched", 1'b1, 1'b0, 1'b0);
        issue(OP_CONTROL_REGISTER_FOUR_WRITE, 2'h0, 64'h0);
        check("prevention_off", prev, 1'b0);
        issue(OP_STORE_TASK_REGISTER, 2'h3, 64'h0);
        verdict_is("store_after_off", 1'b1, 1'b0, 1'b0);
        // Enable again, then a mid-run reset must clear it
        issue(OP_CONTROL_REGISTER_FOUR_WRITE, 2'h0, on_val);
        do_reset();
        check("prevention_after_reset", prev,
            CTRL_FOUR_RESET[PREVENT_BIT]);
        $display("test prevention done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n_in = 1'b0;
        req = '0;
        os_st = 2'h0;
        os_al = 2'h0;
        os_ir = 2'h0;
        repeat (20) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        check("reset_verdict", vd, '0);
        check("reset_prevention", prev, 1'b0);
        test_fixed_levels();
        test_os_levels();
        test_query();
        test_prevention();
        give_verdict();
    end
endmodule // system_instr_privilege_check_bench

`default_nettype wire
